// >>> core/rsec_pkg.sv
// Shared types and constants for the scan entry checker.
// Assumes one 20 MHz clock and entries presented one at a time.
package rsec_pkg;

  localparam int         RSEC_ENTRIES = 128;
  localparam int         RSEC_GROUPS  = 8;
  localparam logic [7:0] RSEC_PORT1   = 8'h01;
  localparam logic [7:0] RSEC_PORT2   = 8'h02;
  localparam logic [7:0] RSEC_RACK_MAX = 8'h3F;
  localparam logic [7:0] RSEC_GRP_MAX = 8'h06;
  localparam logic [7:0] RSEC_WRD_MIN = 8'h02;
  localparam logic [7:0] RSEC_WRD_MAX = 8'h08;
  localparam logic [3:0] RSEC_COIL_LSN = 4'h1;

  localparam logic [15:0] RSEC_OK        = 16'h0000;
  localparam logic [15:0] RSEC_NOT_POLL  = 16'hF001;
  localparam logic [15:0] RSEC_NO_REPLY  = 16'hE001;
  localparam logic [15:0] RSEC_SIZE_BASE = 16'hE020;
  localparam logic [15:0] RSEC_BAD_BASE  = 16'hE030;
  localparam logic [15:0] RSEC_BAD_PORT  = 16'hE044;
  localparam logic [15:0] RSEC_BAD_RANGE = 16'hE045;
  localparam logic [15:0] RSEC_DUP_BASE  = 16'hE100;

  // Bit rate codes of a link port
  typedef enum logic [1:0] {
    RSEC_RATE_OFF  = 2'h0,
    RSEC_RATE_57K6 = 2'h1,
    RSEC_RATE_115K = 2'h2,
    RSEC_RATE_230K = 2'h3
  } rsec_rate_t;

  // Kind of a host memory reference
  typedef enum logic [1:0] {
    RSEC_REF_NONE  = 2'h0,
    RSEC_REF_HOLD  = 2'h1,
    RSEC_REF_COIL  = 2'h2,
    RSEC_REF_INREG = 2'h3
  } rsec_ref_t;

  typedef struct packed {
    logic [6:0]  idx;
    logic [7:0]  port;
    logic [7:0]  rack;
    logic [7:0]  group;
    logic [7:0]  words;
    rsec_ref_t   rd_kind;
    logic [15:0] rd_addr;
    rsec_ref_t   wr_kind;
    logic [15:0] wr_addr;
    logic        rd_used;
    logic        wr_used;
    logic        clear_on_loss;
    logic [7:0]  unit_identifier;
    logic [15:0] health_tout;
    logic [15:0] rep_rate;
    logic        polled;
    logic        replied;
    logic [7:0]  dev_words;
    logic [15:0] in_data;
  } rsec_entry_t;

  typedef struct packed {
    logic [6:0]  idx;
    logic [15:0] code;
    logic        health;
    logic [7:0]  first_rack;
    logic [1:0]  rack_count;
    logic [15:0] in_data;
  } rsec_result_t;

endpackage

// >>> core/rsec_checker.sv
// Scan entry decoder and checker with health and diagnostic blocks.
// Assumes synchronous inputs and one entry offered per valid/ready.
`timescale 1ns/10ps

// Behaviour
// - A group is one 16-bit input word with one 16-bit output word.
// - A full logical rack holds eight groups, numbered zero to seven.
// - An adapter running past group seven also takes the next rack.
// - An adapter owns its start rack plus racks its groups need.
// - Config bytes zero and two set port rates; codes 1,2,3.
// - Health block keeps 128 bits, one per scan entry.
// - Diagnostic block keeps 128 registers, one code per entry.
// - Codes 0000 clean, F001 not yet polled, E001 no reply.
// - Adapter size mismatch gives E02x, x is adapter word count.
// - Bad entry gives E031-E037 from input, output, size flags.
// - Port byte other than 1 or 2 gives E044.
// - Rack or group outside range gives E045.
// - Duplicate of an adapter on another line gives E1xx.
// - Slave field bytes are port, rack, start group, word count.
// - Unit identifier, health timeout, repetition rate are ignored.
// - Input goes to holding register or word-aligned coil.
// - Output comes from holding register or word-aligned coil.
// - Slave field sizes transfer; length fields only flag use.
// - On lost adapter, clear or hold inputs per last-value setting.
// - With no reply and clearing selected, inputs read zero.
module rsec_checker
  import rsec_pkg::*;
(
  input  wire logic          CLOCK,
  input  wire logic          RSTN,
  // Port rate configuration
  input  wire logic          CFG_LOAD,
  input  wire logic [7:0]    CFG_BYTE0,
  input  wire logic [7:0]    CFG_BYTE2,
  output rsec_rate_t         PORT1_RATE,
  output rsec_rate_t         PORT2_RATE,
  // Entry stream in
  input  wire logic          ENT_VALID,
  output logic               ENT_READY,
  input  wire rsec_entry_t   ENT,
  // Result stream out
  output logic               RES_VALID,
  input  wire logic          RES_READY,
  output rsec_result_t       RES,
  // Status blocks
  output logic [127:0]       HEALTH,
  input  wire logic [6:0]    DIAG_ADDR,
  output logic [15:0]        DIAG_DATA
);

  localparam logic [10:0] SLOT_ONE = 11'h001;
  localparam logic [1:0]  CNT_FULL = 2'h2;
  localparam logic [1:0]  CNT_ONE  = 2'h1;
  localparam logic [1:0]  CNT_NONE = 2'h0;

  logic [15:0]  diag_mem [RSEC_ENTRIES];
  logic [15:0]  last_mem [RSEC_ENTRIES];
  logic [7:0]   tbl_port [RSEC_ENTRIES];
  logic [10:0]  tbl_lo   [RSEC_ENTRIES];
  logic [10:0]  tbl_hi   [RSEC_ENTRIES];
  logic [127:0] tbl_vld_r;
  logic [127:0] health_r;
  logic [15:0]  diag_data_r;
  rsec_rate_t   p1_rate_r;
  rsec_rate_t   p2_rate_r;

  rsec_result_t b0_r;
  rsec_result_t b1_r;
  logic [1:0]   cnt_r;
  logic [1:0]   cnt_nxt;
  logic         ent_rdy_r;
  logic         res_vld_r;

  // Decode of the slave field and references
  wire ent_fire = ENT_VALID & ent_rdy_r;
  wire rd_ok = !ENT.rd_used
             | (ENT.rd_kind == RSEC_REF_HOLD)
             | (ENT.rd_kind == RSEC_REF_COIL
                & ENT.rd_addr[3:0] == RSEC_COIL_LSN);
  wire wr_ok = !ENT.wr_used
             | (ENT.wr_kind == RSEC_REF_HOLD)
             | (ENT.wr_kind == RSEC_REF_COIL
                & ENT.wr_addr[3:0] == RSEC_COIL_LSN);
  wire size_ok = !ENT.words[0] & ENT.words >= RSEC_WRD_MIN
               & ENT.words <= RSEC_WRD_MAX;
  wire port_ok = ENT.port == RSEC_PORT1
               | ENT.port == RSEC_PORT2;
  wire range_ok = ENT.rack <= RSEC_RACK_MAX
                & !ENT.group[0] & ENT.group <= RSEC_GRP_MAX;
  wire [2:0] bad_flags = {!size_ok, !wr_ok, !rd_ok};

  // Slot = rack * 8 + group; the last byte alone gives the span
  wire [10:0] slot_lo = {ENT.rack, 3'h0}
                      + {3'h0, ENT.group};
  wire [10:0] slot_hi = slot_lo + {3'h0, ENT.words}
                      - SLOT_ONE;
  wire [7:0]  end_grp = ENT.group + ENT.words;
  wire        spills  = end_grp > 8'(RSEC_GROUPS);
  wire [1:0]  rack_cnt = spills ? 2'h2 : 2'h1;

  // Overlap of this adapter with every other stored line
  logic [127:0] dup_vec;
  genvar g;
  generate
    for (g = 0; g < RSEC_ENTRIES; g++) begin : g_dup
      assign dup_vec[g] = tbl_vld_r[g] & (7'(g) != ENT.idx)
                        & (tbl_port[g] == ENT.port)
                        & (tbl_lo[g] <= slot_hi)
                        & (slot_lo <= tbl_hi[g]);
    end
  endgenerate

  function automatic logic [7:0] first_line(input logic [127:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = RSEC_ENTRIES - 1; i >= 0; i--) begin
      if (v[i]) begin
        n = 8'(i + 1);
      end
    end
    return n;
  endfunction

  wire        dup_hit  = |dup_vec;
  wire [7:0]  dup_line = first_line(dup_vec);
  wire        cfg_err  = |bad_flags | !port_ok | !range_ok | dup_hit;

  // Code priority: entry faults, then adapter state
  wire [15:0] code =
      |bad_flags ? (RSEC_BAD_BASE | {13'h0, bad_flags})
    : !port_ok   ? RSEC_BAD_PORT
    : !range_ok  ? RSEC_BAD_RANGE
    : dup_hit    ? (RSEC_DUP_BASE | {8'h00, dup_line})
    : !ENT.polled  ? RSEC_NOT_POLL
    : !ENT.replied ? RSEC_NO_REPLY
    : ENT.dev_words != ENT.words
      ? (RSEC_SIZE_BASE | {12'h000, ENT.dev_words[3:0]})
    : RSEC_OK;

  wire        good    = code == RSEC_OK;
  // Lost adapter: zero or last held word
  wire [15:0] in_word = good ? ENT.in_data
                      : ENT.clear_on_loss ? 16'h0000
                      : last_mem[ENT.idx];

  rsec_result_t res_new;
  assign res_new.idx        = ENT.idx;
  assign res_new.code       = code;
  assign res_new.health     = good;
  assign res_new.first_rack = ENT.rack;
  assign res_new.rack_count = rack_cnt;
  assign res_new.in_data    = in_word;

  // Diagnostic and health written in the same edge
  always_ff @(posedge CLOCK) begin
    if (ent_fire) begin
      diag_mem[ENT.idx] <= code;
      tbl_port[ENT.idx] <= ENT.port;
      tbl_lo[ENT.idx]   <= slot_lo;
      tbl_hi[ENT.idx]   <= slot_hi;
    end
    if (ent_fire & good) begin
      last_mem[ENT.idx] <= ENT.in_data;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      health_r  <= '0;
      tbl_vld_r <= '0;
    end else if (ent_fire) begin
      health_r[ENT.idx]  <= good;
      tbl_vld_r[ENT.idx] <= !cfg_err;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      diag_data_r <= RSEC_OK;
    end else begin
      diag_data_r <= diag_mem[DIAG_ADDR];
    end
  end

  // Port rates; an unknown code keeps the previous rate
  wire rate0_ok = CFG_BYTE0 >= 8'(RSEC_RATE_57K6)
                & CFG_BYTE0 <= 8'(RSEC_RATE_230K);
  wire rate2_ok = CFG_BYTE2 >= 8'(RSEC_RATE_57K6)
                & CFG_BYTE2 <= 8'(RSEC_RATE_230K);

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      p1_rate_r <= RSEC_RATE_OFF;
      p2_rate_r <= RSEC_RATE_OFF;
    end else if (CFG_LOAD) begin
      if (rate0_ok) begin
        p1_rate_r <= rsec_rate_t'(CFG_BYTE0[1:0]);
      end
      if (rate2_ok) begin
        p2_rate_r <= rsec_rate_t'(CFG_BYTE2[1:0]);
      end
    end
  end

  // Two-entry result buffer; head entry drives the outputs
  wire pop  = (cnt_r != CNT_NONE) & RES_READY;
  wire push = ent_fire;
  assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  wire b0_take_new = push & ((cnt_r == CNT_NONE)
                   | (cnt_r == CNT_ONE & pop));
  wire b0_take_b1  = pop & cnt_r == CNT_FULL;
  wire b1_take_new = push & ((cnt_r == CNT_ONE & !pop)
                   | (cnt_r == CNT_FULL & pop));

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_r     <= CNT_NONE;
      ent_rdy_r <= 1'b1;
      res_vld_r <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      ent_rdy_r <= cnt_nxt != CNT_FULL;
      res_vld_r <= cnt_nxt != CNT_NONE;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      b0_r <= '0;
      b1_r <= '0;
    end else begin
      if (b0_take_b1) begin
        b0_r <= b1_r;
      end else if (b0_take_new) begin
        b0_r <= res_new;
      end
      if (b1_take_new) begin
        b1_r <= res_new;
      end
    end
  end

  assign ENT_READY  = ent_rdy_r;
  assign RES_VALID  = res_vld_r;
  assign RES        = b0_r;
  assign HEALTH     = health_r;
  assign DIAG_DATA  = diag_data_r;
  assign PORT1_RATE = p1_rate_r;
  assign PORT2_RATE = p2_rate_r;

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  health_diag_a: assert property (
    ent_fire |=> health_r[$past(ENT.idx)] == ($past(code) == RSEC_OK)
                 && diag_mem[$past(ENT.idx)] == $past(code))
    else $error("health bit and diag code disagree");

  bad_flags_a: assert property (
    ent_fire && |bad_flags |-> code[15:4] == RSEC_BAD_BASE[15:4]
                 && code[2:0] == bad_flags)
    else $error("bad entry code wrong");

  port_code_a: assert property (
    ent_fire && !(|bad_flags) && ENT.port == 8'h03
      |-> code == RSEC_BAD_PORT)
    else $error("bad port not reported");

  range_code_a: assert property (
    ent_fire && !(|bad_flags) && port_ok && ENT.group == 8'h03
      |-> code == RSEC_BAD_RANGE)
    else $error("odd group not reported");

  dup_code_a: assert property (
    ent_fire && code[15:8] == RSEC_DUP_BASE[15:8]
      |-> dup_hit && code[7:0] != 8'h00)
    else $error("duplicate code without a match");

  size_code_a: assert property (
    ent_fire && !cfg_err && ENT.polled && ENT.replied
      && ENT.dev_words != ENT.words
      |-> code[15:4] == RSEC_SIZE_BASE[15:4]
          && code[3:0] == ENT.dev_words[3:0])
    else $error("size mismatch code wrong");

  loss_zero_a: assert property (
    push && code == RSEC_NO_REPLY && ENT.clear_on_loss
      && cnt_r == CNT_NONE |=> RES.in_data == 16'h0000)
    else $error("inputs not cleared on loss");

  rack_span_a: assert property (
    push && cnt_r == CNT_NONE && ENT.group == 8'h06
      && ENT.words == 8'h04 |=> RES.rack_count == 2'h2)
    else $error("spill into next rack missed");

  rate_load_a: assert property (
    CFG_LOAD && CFG_BYTE0 == 8'h03 |=> PORT1_RATE == RSEC_RATE_230K)
    else $error("port one rate not loaded");

  buf_hold_a: assert property (
    RES_VALID && !RES_READY |=> RES_VALID && $stable(RES))
    else $error("result changed while stalled");

  buf_full_a: assert property (
    cnt_r == CNT_FULL |-> !ENT_READY)
    else $error("buffer accepts while full");

  no_poll_a: assert property (
    ent_fire && !cfg_err && !ENT.polled |-> code == RSEC_NOT_POLL)
    else $error("unpolled adapter not reported");

  hold_last_a: assert property (
    push && !good && !ENT.clear_on_loss && cnt_r == CNT_NONE
      |=> RES.in_data == $past(last_mem[ENT.idx]))
    else $error("inputs not held on loss");

  first_rack_a: assert property (
    push && cnt_r == CNT_NONE |=> RES.first_rack == $past(ENT.rack))
    else $error("start rack not passed on");

  coil_src_a: assert property (
    ent_fire && ENT.wr_used && ENT.wr_kind == RSEC_REF_COIL
      && ENT.wr_addr[3:0] != RSEC_COIL_LSN
      |-> code[15:4] == RSEC_BAD_BASE[15:4] && code[1])
    else $error("unaligned coil source accepted");

  rate2_load_a: assert property (
    CFG_LOAD && CFG_BYTE2 == 8'h01 |=> PORT2_RATE == RSEC_RATE_57K6)
    else $error("port two rate not loaded");

  rate_keep_a: assert property (
    CFG_LOAD && !rate0_ok |=> $stable(PORT1_RATE))
    else $error("port one rate changed on bad code");

  fill_c: cover property (cnt_r == CNT_FULL ##1 !RES_READY);
  noreply_c: cover property (ent_fire && code == RSEC_NO_REPLY);
  dup_c: cover property (ent_fire && dup_hit);
  ok_c: cover property (ent_fire && good ##1 RES_VALID);

endmodule

// >>> verif/rsec_sink.sv
// Result consumer model with random back-pressure and a hard stall.
// Assumes it takes the result stream of the checker, one word a beat.
`timescale 1ns/10ps
module rsec_sink (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic stall,
  // Result stream
  output logic      res_ready
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      res_ready <= 1'b0;
    else
      res_ready <= !stall && ($urandom_range(3) != 0);
  end
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the scan entry checker.
// Assumes the result consumer model and the shared package.
`timescale 1ns/10ps
module tb_top;
  import rsec_pkg::*;
  logic         CLOCK, RSTN, cfg_load, ent_valid, ent_ready;
  logic         res_valid, res_ready, stall;
  logic [7:0]   cfg_b0, cfg_b2;
  rsec_rate_t   p1, p2;
  rsec_entry_t  ent, e;
  rsec_result_t res, er;
  logic [127:0] health;
  logic [6:0]   diag_addr;
  logic [15:0]  diag_data;
  logic [15:0]  good_d [128];
  logic [15:0]  dg [128];
  bit           dw [128];
  rsec_result_t expq [$];
  bit           rackq [$];
  bit           rk;
  int           num_errors, cmp_count;

  rsec_checker uut (.CLOCK(CLOCK), .RSTN(RSTN), .CFG_LOAD(cfg_load),
    .CFG_BYTE0(cfg_b0), .CFG_BYTE2(cfg_b2), .PORT1_RATE(p1),
    .PORT2_RATE(p2), .ENT_VALID(ent_valid), .ENT_READY(ent_ready),
    .ENT(ent), .RES_VALID(res_valid), .RES_READY(res_ready),
    .RES(res), .HEALTH(health), .DIAG_ADDR(diag_addr),
    .DIAG_DATA(diag_data));
  rsec_sink sink (.clk(CLOCK), .rst_n(RSTN), .stall(stall),
    .res_ready(res_ready));

  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  task automatic chk(input string n, input logic [15:0] x, g);
    cmp_count++;
    if (g !== x) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic [15:0] exp_code(input rsec_entry_t x);
    logic [2:0] f;
    f[0] = x.rd_used && !(x.rd_kind == RSEC_REF_HOLD ||
      x.rd_kind == RSEC_REF_COIL && x.rd_addr[3:0] == 4'h1);
    f[1] = x.wr_used && !(x.wr_kind == RSEC_REF_HOLD ||
      x.wr_kind == RSEC_REF_COIL && x.wr_addr[3:0] == 4'h1);
    f[2] = x.words < RSEC_WRD_MIN || x.words > RSEC_WRD_MAX;
    if (f != 3'h0) return RSEC_BAD_BASE | 16'(f);
    if (x.port != RSEC_PORT1 && x.port != RSEC_PORT2) return RSEC_BAD_PORT;
    if (x.rack > RSEC_RACK_MAX || x.group > RSEC_GRP_MAX || x.group[0])
      return RSEC_BAD_RANGE;
    if (!x.polled) return RSEC_NOT_POLL;
    if (!x.replied) return RSEC_NO_REPLY;
    if (x.dev_words != x.words) return RSEC_SIZE_BASE | 16'(x.dev_words[3:0]);
    return RSEC_OK;
  endfunction

  // Clean entry with random ignored fields; group 0 and even word count
  function automatic rsec_entry_t mk(input int i, input int r);
    logic [159:0] w;
    rsec_entry_t  x;
    w = {$urandom, $urandom, $urandom, $urandom, $urandom};
    x = w[$bits(rsec_entry_t)-1:0];
    x.idx = 7'(i);
    x.port = 8'($urandom_range(2, 1));
    x.rack = 8'(r);
    x.group = 8'h00;
    x.words = 8'(2 * $urandom_range(4, 1));
    x.rd_kind = RSEC_REF_HOLD;
    x.wr_kind = RSEC_REF_COIL;
    x.wr_addr[3:0] = 4'h1;
    x.polled = 1'b1;
    x.replied = 1'b1;
    x.dev_words = x.words;
    x.clear_on_loss = 1'b1;
    return x;
  endfunction

  task automatic send(input rsec_entry_t x, input logic [15:0] c);
    rsec_result_t r;
    r.idx = x.idx;
    r.code = c;
    r.health = (c == RSEC_OK);
    r.first_rack = x.rack;
    r.rack_count = (x.group + x.words > 8'h08) ? 2'h2 : 2'h1;
    r.in_data = (c == RSEC_OK) ? x.in_data :
      x.clear_on_loss ? 16'h0000 : good_d[x.idx];
    if (c == RSEC_OK) good_d[x.idx] = x.in_data;
    dg[x.idx] = c;
    dw[x.idx] = 1'b1;
    expq.push_back(r);
    rackq.push_back(c == RSEC_OK);
    ent_valid <= 1'b1;
    ent <= x;
    @(negedge CLOCK);
    while (ent_ready !== 1'b1) @(negedge CLOCK);
    @(posedge CLOCK);
  endtask

  always @(posedge CLOCK) begin
    if (RSTN && res_valid === 1'b1 && res_ready === 1'b1) begin
      chk("queue", 16'h0001, 16'(expq.size() != 0));
      er = expq.pop_front();
      rk = rackq.pop_front();
      chk("idx", 16'(er.idx), 16'(res.idx));
      chk("code", er.code, res.code);
      chk("health", 16'(er.health), 16'(res.health));
      chk("hblock", 16'(er.health), 16'(health[res.idx]));
      chk("in_data", er.in_data, res.in_data);
      if (rk) begin
        chk("rack", 16'(er.first_rack), 16'(res.first_rack));
        chk("racks", 16'(er.rack_count), 16'(res.rack_count));
      end
    end
  end

  initial begin
    #(50 * 30000);
    num_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h0AED));
    {RSTN, cfg_load, ent_valid, stall} = 4'h0;
    {cfg_b0, cfg_b2, diag_addr} = 23'h0;
    ent = '0;
    repeat (6) @(posedge CLOCK);
    RSTN <= 1'b1;
    @(negedge CLOCK);
    chk("reset", 16'h0001, {14'h0, res_valid, ent_ready});
    chk("hreset", 16'h0000, 16'(|health));
    for (int c = 0; c < 5; c++) begin
      @(posedge CLOCK);
      cfg_load <= 1'b1;
      cfg_b0 <= 8'(c);
      cfg_b2 <= 8'(4 - c);
      @(posedge CLOCK);
      cfg_load <= 1'b0;
      @(negedge CLOCK);
      chk("rate1", 16'((c == 0) ? 0 : (c == 4) ? 3 : c), 16'(p1));
      chk("rate2", 16'((c == 0) ? 0 : (c == 4) ? 1 : 4 - c), 16'(p2));
    end
    @(posedge CLOCK);
    for (int i = 0; i < 40; i++) send(mk(i, i), RSEC_OK);
    e = mk(40, 40);
    e.polled = 1'b0;
    send(e, exp_code(e));
    e = mk(41, 41);
    send(e, RSEC_OK);
    ent_valid <= 1'b0;
    while (expq.size() != 0) @(posedge CLOCK);
    e.replied = 1'b0;
    e.clear_on_loss = 1'b0;
    send(e, exp_code(e));
    e = mk(42, 42);
    e.replied = 1'b0;
    send(e, exp_code(e));
    e = mk(43, 43);
    e.dev_words = e.words ^ 8'h02;
    send(e, exp_code(e));
    e = mk(45, 45);
    e.group = 8'h06;
    e.words = 8'h04;
    e.dev_words = 8'h04;
    send(e, exp_code(e));
    for (int f = 1; f < 8; f++) begin
      e = mk(60 + f, 0);
      {e.rd_used, e.wr_used} = 2'h3;
      e.rd_kind = f[0] ? RSEC_REF_INREG : RSEC_REF_COIL;
      e.rd_addr[3:0] = 4'h1;
      e.wr_addr[3:0] = f[1] ? 4'h2 : 4'h1;
      e.words = f[2] ? 8'h0A : 8'h02;
      send(e, exp_code(e));
    end
    e = mk(70, 0);
    e.port = 8'h00;
    send(e, exp_code(e));
    e.idx = 7'd71;
    e.port = 8'h03;
    send(e, exp_code(e));
    e = mk(72, 64);
    send(e, exp_code(e));
    e = mk(73, 1);
    e.group = 8'h03;
    send(e, exp_code(e));
    e = mk(50, 50);
    e.port = RSEC_PORT1;
    {e.words, e.dev_words} = 16'h0404;
    send(e, RSEC_OK);
    e.idx = 7'd51;
    e.group = 8'h02;
    {e.words, e.dev_words} = 16'h0202;
    send(e, RSEC_DUP_BASE | 16'h0033);
    e.idx = 7'd52;
    e.port = RSEC_PORT2;
    send(e, RSEC_OK);
    ent_valid <= 1'b0;
    while (expq.size() != 0) @(posedge CLOCK);
    stall <= 1'b1;
    repeat (40) @(posedge CLOCK);
    send(mk(53, 53), RSEC_OK);
    send(mk(54, 54), RSEC_OK);
    ent_valid <= 1'b0;
    @(posedge CLOCK);
    @(negedge CLOCK);
    chk("refuse", 16'h0000, 16'(ent_ready));
    @(posedge CLOCK);
    fork
      send(mk(55, 55), RSEC_OK);
      begin
        repeat (6) @(posedge CLOCK);
        stall <= 1'b0;
      end
    join
    ent_valid <= 1'b0;
    for (int k = 0; k < 300 && expq.size() != 0; k++) @(posedge CLOCK);
    chk("drain", 16'h0000, 16'(expq.size()));
    for (int i = 0; i < 128; i++) begin
      if (dw[i]) begin
        @(posedge CLOCK);
        diag_addr <= 7'(i);
        @(posedge CLOCK);
        @(negedge CLOCK);
        chk("diag", dg[i], diag_data);
      end
    end
    print_verdict();
  end
endmodule
